// [bench/csc_config_regs_chk.sv]
`timescale 1ns/10ps
`default_nettype none
// ====
// Port checker for the configuration registers
module csc_config_regs_chk #(
   parameter int unsigned SETTLE_CYCLES = 4
) (
   // Clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_in,
   // Observed pins
   input  wire csc_pkg::csc_spi_in_t spi_in,
   input  wire logic                 spi_sdo_out,
   input  wire logic [1:0]           mode_out,
   input  wire logic                 power_down_out,
   input  wire logic                 soft_reset_busy_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic [2:0] sclk_r;
   // Length of the current settling window, so its span is checked exactly
   always_comb cnt_nxt = soft_reset_busy_out ? cnt_r + 8'h01 : 8'h00;
   always_ff @(posedge clk_in) begin
      cnt_r  <= rst_in ? 8'h00 : cnt_nxt;
      sclk_r <= {sclk_r[1:0], spi_in.sclk};
   end
   pdn_decode_a: assert property (power_down_out == (mode_out == 2'h3))
      else $error("power down flag disagrees with mode");
   mode_legal_a: assert property (mode_out != 2'h1 && mode_out != 2'h2)
      else $error("reserved mode reached the pins");
   sdo_idle_a: assert property ($past(spi_in.cs_n) && spi_in.cs_n |-> !spi_sdo_out)
      else $error("serial output active while deselected");
   // Output may move only one or two clocks after a serial clock fall or after cs_n was seen high
   sdo_timing_a: assert property ($changed(spi_sdo_out) |-> $past(spi_in.cs_n)
      || $past(spi_in.cs_n, 2) || (!sclk_r[0] && sclk_r[1]) || (!sclk_r[1] && sclk_r[2]))
      else $error("serial output moved off a clock fall");
   settle_bound_a: assert property (soft_reset_busy_out |-> cnt_r < 8'(SETTLE_CYCLES))
      else $error("settling window too long");
   settle_len_a: assert property ($fell(soft_reset_busy_out) |-> cnt_r == 8'(SETTLE_CYCLES))
      else $error("settling window length wrong");
   settle_clear_a: assert property (soft_reset_busy_out |-> mode_out == 2'h0)
      else $error("mode not cleared by soft reset");
   mode_frame_a: assert property ($changed(mode_out) |-> !$past(spi_in.cs_n))
      else $error("mode changed outside a frame");
endmodule : csc_config_regs_chk
bind csc_config_regs csc_config_regs_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk (
   .clk_in(clk_in), .rst_in(rst_in), .spi_in(spi_in), .spi_sdo_out(spi_sdo_out),
   .mode_out(mode_out), .power_down_out(power_down_out),
   .soft_reset_busy_out(soft_reset_busy_out));
`default_nettype wire

// [bench/csc_config_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "csc_params.svh"
// ====
// Register tests over the serial port
module csc_config_regs_tb;
   csc_pkg::csc_spi_in_t spi;
   logic                 clk_in;
   logic                 rst_in;
   logic                 sdo;
   logic                 pdn;
   logic                 busy;
   logic [1:0]           mode;
   logic [31:0]          rd;
   int                   err_count;
   int                   checks;
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   // Short settling count keeps the run brief
   csc_config_regs #(.SETTLE_CYCLES(4)) uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
      .spi_in(spi), .spi_sdo_out(sdo), .mode_out(mode), .power_down_out(pdn),
      .soft_reset_busy_out(busy));
   csc_spi_host host (.clk_in(clk_in), .sdo_in(sdo), .busy_in(busy), .spi_out(spi));
   task automatic conclude;
      if (err_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %0t byte %h expected %h", $time, got, exp);
      end
   endtask : cmp8
   task automatic cmp_pins(input logic [3:0] exp);
      checks++;
      if ({mode, pdn, busy} !== exp) begin
         err_count++;
         $display("mismatch %0t pins %b expected %b", $time, {mode, pdn, busy}, exp);
      end
   endtask : cmp_pins
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      host.xfer(1'b0, a, 1, {d, 24'h0}, rd);
   endtask : wr
   task automatic rd1(input logic [14:0] a, input logic [7:0] exp);
      host.xfer(1'b1, a, 1, 32'h0, rd);
      cmp8(rd[31:24], exp);
   endtask : rd1
   // Watchdog well beyond the expected run
   initial begin
      #1000000;
      err_count++;
      conclude();
   end
   initial begin
      err_count = 0;
      checks = 0;
      rst_in = 1'b1;
      repeat (12) @(negedge clk_in);
      rst_in = 1'b0;
      rd1(`CSC_ADDR_IFCFG, 8'h30);
      rd1(`CSC_ADDR_OPMODE, 8'h00);
      rd1(`CSC_ADDR_DEVCLS, 8'h0A);
      rd1(15'h0001, 8'h00);
      wr(`CSC_ADDR_IFCFG, 8'h4F);
      rd1(`CSC_ADDR_IFCFG, 8'h5F);
      // Descending stream: class byte, then mode byte one below
      host.xfer(1'b0, `CSC_ADDR_DEVCLS, 2, 32'h5503_0000, rd);
      rd1(`CSC_ADDR_DEVCLS, 8'h5A);
      cmp_pins(4'b1110);
      for (int m = 1; m < 3; m++) begin
         wr(`CSC_ADDR_OPMODE, 8'(m));
         rd1(`CSC_ADDR_OPMODE, 8'h03);
      end
      wr(`CSC_ADDR_IFCFG, 8'h30);
      host.xfer(1'b1, `CSC_ADDR_OPMODE, 2, 32'h0, rd);
      cmp8(rd[31:24], 8'h03);
      cmp8(rd[23:16], 8'h5A);
      wr(`CSC_ADDR_HOLD, 8'h01);
      host.xfer(1'b1, `CSC_ADDR_DEVCLS, 2, 32'h0, rd);
      cmp8(rd[31:24], 8'h5A);
      cmp8(rd[23:16], 8'h5A);
      // Soft reset; the trailing bytes would make a mode write unless dropped
      host.xfer(1'b0, `CSC_ADDR_IFCFG, 4, 32'h8000_0203, rd);
      rd1(`CSC_ADDR_IFCFG, 8'h30);
      rd1(`CSC_ADDR_OPMODE, 8'h00);
      rd1(`CSC_ADDR_DEVCLS, 8'h0A);
      rd1(`CSC_ADDR_HOLD, 8'h00);
      cmp_pins(4'b0000);
      conclude();
   end
endmodule : csc_config_regs_tb
`default_nettype wire

// [bench/csc_spi_host.sv]
`timescale 1ns/10ps
`default_nettype none
// ====
// Mode 0 host; three clocks a level keeps the serial clock slow enough
module csc_spi_host (
   // Clock and device status
   input  wire logic            clk_in,
   input  wire logic            sdo_in,
   input  wire logic            busy_in,
   // Lines toward the device
   output var csc_pkg::csc_spi_in_t spi_out
);
   initial spi_out = 3'b100;
   // One byte, MSB first; read bit taken just before the rise
   task automatic shift8(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         spi_out.sdi = b[i];
         repeat (3) @(negedge clk_in);
         r[i] = sdo_in;
         spi_out.sclk = 1'b1;
         repeat (3) @(negedge clk_in);
         spi_out.sclk = 1'b0;
      end
   endtask : shift8
   // Header then n bytes, packed from the top byte down
   task automatic xfer(input logic rd, input logic [14:0] a, input int n,
                       input logic [31:0] wd, output logic [31:0] rdat);
      logic [7:0] rb;
      for (int k = 0; k < 200 && busy_in; k++) @(negedge clk_in);
      @(negedge clk_in);
      spi_out.cs_n = 1'b0;
      shift8({rd, a[14:8]}, rb);
      shift8(a[7:0], rb);
      rdat = '0;
      for (int j = 0; j < n; j++) begin
         shift8(wd[31-8*j -: 8], rb);
         rdat[31-8*j -: 8] = rb;
      end
      repeat (3) @(negedge clk_in);
      spi_out.cs_n = 1'b1;
      // Released data line shows the inverse, not a stale bit
      spi_out.sdi = ~spi_out.sdi;
   endtask : xfer
endmodule : csc_spi_host
`default_nettype wire

// [include/csc_params.svh]
// Summary of operation
// [R1] Writing one to the soft-reset bit resets every register, then the bit self-clears.
// [R2] Reset completes within 750 ns; host starts no transaction meanwhile.
// [R3] Streaming address steps down when direction bit is zero, up when one; resets one.
// [R4] Serial-output flag always reads one; read data leaves only on the serial output.
// [R5] Mode field: 0 normal (reset value), 3 power-down; 1 and 2 reserved.
// [R6] Device-class bits 3:0 are read-only and return a fixed converter code.
// [R7] Address-freeze bit holds the address constant during streaming, overriding direction.
// [R8] Writes to read-only fields leave their returned values unchanged.
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

// ==========================================================================
// Register addresses
`define CSC_ADDR_IFCFG    15'h0000
`define CSC_ADDR_OPMODE   15'h0002
`define CSC_ADDR_DEVCLS   15'h0003
`define CSC_ADDR_HOLD     15'h0010

// ==========================================================================
// Field positions
`define CSC_SOFT_RST_BIT  7
`define CSC_ASCEND_BIT    5
`define CSC_SDO_FLAG_BIT  4
`define CSC_HOLD_BIT      0
`define CSC_IFCFG_WMASK   8'h6F
`define CSC_MODE_MSB      1

// ==========================================================================
// Reset values and encodings
`define CSC_IFCFG_RST     8'h30
`define CSC_OPMODE_RST    8'h00
`define CSC_HOLD_RST      8'h00
`define CSC_DEVCLS_HI_RST 4'h0
`define CSC_MODE_NORMAL   2'h0
`define CSC_MODE_RSVD1    2'h1
`define CSC_MODE_RSVD2    2'h2
`define CSC_MODE_PDN      2'h3
// Arbitrary device-class code, not tied to any real part
`define CSC_DEVCLS_CODE   4'hA

// ==========================================================================
// Serial framing
`define CSC_HDR_LAST      4'hF
`define CSC_BYTE_LAST     4'h7
`define CSC_RW_BIT        14

// ==========================================================================
// Timing
`define CSC_SETTLE_NS     750
`define CSC_CLK_PERIOD_NS 20
// Rounded down so the port is live again inside the promised settling window
`define CSC_SETTLE_CYC    (`CSC_SETTLE_NS / `CSC_CLK_PERIOD_NS)

`endif

// [include/csc_pkg.sv]
package csc_pkg;

   // ========================================================================
   // Types
   typedef enum logic [3:0] {
      CSC_ST_IDLE = 4'h1,
      CSC_ST_HDR  = 4'h2,
      CSC_ST_DATA = 4'h4,
      CSC_ST_DROP = 4'h8
   } csc_state_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic sdi;
   } csc_spi_in_t;

   typedef struct packed {
      logic [7:0] ifcfg;
      logic [7:0] opmode;
      logic [3:0] devcls_hi;
      logic [7:0] hold;
   } csc_regs_t;

   typedef struct packed {
      csc_state_t  state;
      csc_regs_t   regs;
      logic        sclk_q;
      logic [15:0] shift;
      logic [3:0]  bitcnt;
      logic        rd;
      logic [14:0] addr;
      logic        sdo;
   } csc_main_t;

   typedef struct packed {
      logic [7:0] count;
   } csc_tmr_t;

endpackage : csc_pkg

// [src/csc_config_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "csc_params.svh"

module csc_config_regs #(
   parameter int unsigned SETTLE_CYCLES = `CSC_SETTLE_CYC
) (
   // Clock, reset, enable
   input  wire logic                 clk_in,
   input  wire logic                 rst_in,
   input  wire logic                 ce_in,
   // Serial control port
   input  wire csc_pkg::csc_spi_in_t spi_in,
   output logic                      spi_sdo_out,
   // Chip control
   output logic [1:0]                mode_out,
   output logic                      power_down_out,
   output logic                      soft_reset_busy_out
);

   // Power-up and soft-reset image of the whole engine
   localparam csc_pkg::csc_main_t MAIN_RST = '{
      state:  csc_pkg::CSC_ST_IDLE,
      regs:   '{ifcfg: `CSC_IFCFG_RST, opmode: `CSC_OPMODE_RST,
                devcls_hi: `CSC_DEVCLS_HI_RST, hold: `CSC_HOLD_RST},
      sclk_q: 1'b0,
      shift:  16'h0000,
      bitcnt: 4'h0,
      rd:     1'b0,
      addr:   15'h0000,
      sdo:    1'b0
   };

   csc_pkg::csc_main_t s_r;
   csc_pkg::csc_main_t s_nxt;
   // Soft-reset strobe and settling status
   logic               srst_now;
   logic               busy;

   // ========================================================================
   // Read view of the register map. Unmapped addresses read zero. The flag
   // bit is forced here rather than stored, so no write can ever clear it,
   // and the class code is a constant, so no write can ever reach it.
   function automatic logic [7:0] read_reg(input csc_pkg::csc_regs_t r,
                                           input logic [14:0] a);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         `CSC_ADDR_IFCFG: begin
            d = r.ifcfg & `CSC_IFCFG_WMASK;
            d[`CSC_SDO_FLAG_BIT] = 1'b1;               // R4
         end
         `CSC_ADDR_OPMODE: d = r.opmode;
         `CSC_ADDR_DEVCLS: d = {r.devcls_hi, `CSC_DEVCLS_CODE};  // R6
         `CSC_ADDR_HOLD:   d = r.hold;
         default:          d = 8'h00;
      endcase
      return d;
   endfunction : read_reg

   // ========================================================================
   // Next streaming address. Freeze beats direction; the address simply
   // wraps at either end of the address space.
   function automatic logic [14:0] step_addr(input csc_pkg::csc_regs_t r,
                                             input logic [14:0] a);
      logic [14:0] n;
      n = a;
      if (r.hold[`CSC_HOLD_BIT]) begin
         n = a;                                          // R7
      end else if (r.ifcfg[`CSC_ASCEND_BIT]) begin
         n = a + 15'h0001;                               // R3
      end else begin
         n = a - 15'h0001;                               // R3
      end
      return n;
   endfunction : step_addr

   // ========================================================================
   // Serial engine and register writes
   // A frame is cs_n low, sixteen header bits (read flag, then a 15-bit
   // address), then whole bytes, most significant bit first. The serial clock
   // is oversampled by clk_in, so each serial level must last at least one
   // clk_in period or an edge is lost. Read bits launch on the clk_in edge
   // after a serial fall and hold to the next fall, which gives the host a
   // serial half period, less up to one clk_in period, of setup before its sampling rise. The address
   // steps after every byte unless frozen, so a stream simply walks on past the end of the
   // map and reads zeros there.
   always_comb begin
      logic       rise;
      logic       fall;
      logic [7:0] wd;
      logic [1:0] mode_w;
      rise     = spi_in.sclk & ~s_r.sclk_q;
      fall     = ~spi_in.sclk & s_r.sclk_q;
      wd       = {s_r.shift[6:0], spi_in.sdi};
      mode_w   = 2'h0;
      s_nxt    = s_r;
      srst_now = 1'b0;
      s_nxt.sclk_q = spi_in.sclk;
      // Settling window ignores the port entirely and poisons the open frame
      if (busy) begin
         s_nxt        = MAIN_RST;                        // R2
         s_nxt.state  = csc_pkg::CSC_ST_DROP;
         s_nxt.sclk_q = spi_in.sclk;
      end else if (spi_in.cs_n) begin
         // Deselect ends any frame, a dropped one too, and parks the output low
         s_nxt.state  = csc_pkg::CSC_ST_IDLE;
         s_nxt.bitcnt = 4'h0;
         s_nxt.sdo    = 1'b0;
      end else begin
         case (s_r.state)
            // First selected cycle enters the header; bits count on serial rises
            csc_pkg::CSC_ST_IDLE, csc_pkg::CSC_ST_HDR: begin
               s_nxt.state = csc_pkg::CSC_ST_HDR;
               if (rise) begin
                  s_nxt.shift  = {s_r.shift[14:0], spi_in.sdi};
                  s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                  if (s_r.bitcnt == `CSC_HDR_LAST) begin
                     s_nxt.state  = csc_pkg::CSC_ST_DATA;
                     s_nxt.bitcnt = 4'h0;
                     s_nxt.rd     = s_r.shift[`CSC_RW_BIT];
                     s_nxt.addr   = {s_r.shift[13:0], spi_in.sdi};
                     s_nxt.shift  = {8'h00, read_reg(s_r.regs, s_nxt.addr)};
                  end
               end
            end
            // Write bytes commit on the eighth rise; a byte cut short is lost
            csc_pkg::CSC_ST_DATA: begin
               // Read bits leave only on the dedicated output
               if (fall && s_r.rd) begin
                  s_nxt.sdo   = s_r.shift[7];                  // R4
                  s_nxt.shift = {s_r.shift[14:0], 1'b0};
               end
               if (rise) begin
                  if (!s_r.rd) begin
                     s_nxt.shift = {s_r.shift[14:0], spi_in.sdi};
                  end
                  s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                  if (s_r.bitcnt == `CSC_BYTE_LAST) begin
                     s_nxt.bitcnt = 4'h0;
                     s_nxt.addr   = step_addr(s_r.regs, s_r.addr);
                     if (s_r.rd) begin
                        s_nxt.shift = {8'h00, read_reg(s_r.regs, s_nxt.addr)};
                     end else begin
                        case (s_r.addr)
                           `CSC_ADDR_IFCFG: begin
                              if (wd[`CSC_SOFT_RST_BIT]) begin
                                 srst_now = 1'b1;                // R1
                              end
                              // Flag bit stays out of storage
                              s_nxt.regs.ifcfg = (wd & `CSC_IFCFG_WMASK)
                                 | (s_r.regs.ifcfg & ~`CSC_IFCFG_WMASK); // R8
                           end
                           `CSC_ADDR_OPMODE: begin
                              // Reserved mode codes keep the old mode
                              mode_w = wd[`CSC_MODE_MSB:0];
                              s_nxt.regs.opmode[7:`CSC_MODE_MSB+1] = wd[7:`CSC_MODE_MSB+1];
                              if (mode_w == `CSC_MODE_NORMAL ||
                                  mode_w == `CSC_MODE_PDN) begin
                                 s_nxt.regs.opmode[`CSC_MODE_MSB:0] = mode_w;  // R5
                              end
                           end
                           `CSC_ADDR_DEVCLS: begin
                              s_nxt.regs.devcls_hi = wd[7:4];       // R8
                           end
                           `CSC_ADDR_HOLD: s_nxt.regs.hold = wd;
                           default: s_nxt.regs = s_r.regs;
                        endcase
                     end
                  end
               end
            end
            csc_pkg::CSC_ST_DROP: begin
               // Bits after a soft reset belong to a dead frame; wait for deselect
               s_nxt.state = csc_pkg::CSC_ST_DROP;
            end
            default: s_nxt.state = csc_pkg::CSC_ST_IDLE;
         endcase
      end
      // Whole-chip reset wins over everything written in this cycle; the edge
      // history keeps tracking the pin so no false edge follows the reset
      if (srst_now) begin
         s_nxt        = MAIN_RST;                        // R1
         s_nxt.state  = csc_pkg::CSC_ST_DROP;
         s_nxt.sclk_q = spi_in.sclk;
      end
   end

   // ========================================================================
   // State register; ce_in low freezes everything, edge history included,
   // so a pause cannot fake a serial edge
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_r <= MAIN_RST;
      end else if (ce_in) begin
         s_r <= s_nxt;
      end
   end

   // ========================================================================
   // Settle timer: the soft reset bit never lands in storage, so it self-clears
   // and the port stays deaf until the count runs out
   csc_settle_timer #(
      .CYCLES (SETTLE_CYCLES)
   ) u_settle (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .ce_in    (ce_in),
      .start_in (srst_now),
      .busy_out (busy)
   );

   // ========================================================================
   // Outputs. Power-down is decoded from the stored field, so it never
   // disagrees with mode_out.
   assign spi_sdo_out         = s_r.sdo;
   assign mode_out            = s_r.regs.opmode[`CSC_MODE_MSB:0];
   assign power_down_out      = (s_r.regs.opmode[`CSC_MODE_MSB:0] == `CSC_MODE_PDN); // R5
   assign soft_reset_busy_out = busy;

endmodule : csc_config_regs
`default_nettype wire

// [src/csc_settle_timer.sv]
`timescale 1ns/10ps
`default_nettype none
`include "csc_params.svh"

module csc_settle_timer #(
   parameter int unsigned CYCLES = `CSC_SETTLE_CYC
) (
   // Clock and control
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic ce_in,
   // Soft reset request and status
   input  wire logic start_in,
   output logic      busy_out
);

   csc_pkg::csc_tmr_t s_r;
   csc_pkg::csc_tmr_t s_nxt;

   // ========================================================================
   // Countdown; holds the block in reset until the settle time has passed
   always_comb begin
      s_nxt = s_r;
      if (start_in) begin
         s_nxt.count = 8'(CYCLES);  // R2
      end else if (s_r.count != 8'h00) begin
         s_nxt.count = s_r.count - 8'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_r <= '{count: 8'h00};
      end else if (ce_in) begin
         s_r <= s_nxt;
      end
   end

   assign busy_out = (s_r.count != 8'h00);

endmodule : csc_settle_timer
`default_nettype wire
